// file: design/mrx_cfg.svh
// Constants for the move, return, rotate and power-down executor
`ifndef MRX_CFG_SVH
`define MRX_CFG_SVH
// Register offsets (byte addresses)
`define MRX_OFS_INSTR   8'h00
`define MRX_OFS_ACC     8'h04
`define MRX_OFS_STATUS  8'h08
`define MRX_OFS_PC      8'h0c
`define MRX_OFS_STACK   8'h10
`define MRX_OFS_WDOG    8'h14
`define MRX_OFS_FADDR   8'h18
`define MRX_OFS_FDATA   8'h1c
`define MRX_OFS_CTRL    8'h20
// Instruction word fields
`define MRX_IW_OP_HI    19
`define MRX_IW_OP_LO    16
`define MRX_IW_DEST     8
`define MRX_IW_ARG_HI   7
// Status bit positions
`define MRX_ST_CARRY    0
`define MRX_ST_ZERO     2
`define MRX_ST_PDOWN    3
`define MRX_ST_TMOUT    4
`define MRX_ST_INTEN    7
`define MRX_ST_BUSY     8
`define MRX_ST_SLEEP    9
// Other field positions
`define MRX_STK_SP_LO   16
`define MRX_WD_PRE_LO   8
`define MRX_CTRL_WAKE   0
// Reset and clear values
`define MRX_RST_TMOUT   1'b1
`define MRX_RST_PDOWN   1'b1
`define MRX_RST_FLAG    1'b0
`define MRX_WDOG_CLR    8'h00
// Opcodes
`define MRX_OP_NOP      4'h0
`define MRX_OP_COPY     4'h1
`define MRX_OP_LOADLIT  4'h2
`define MRX_OP_STORE    4'h3
`define MRX_OP_RETINT   4'h4
`define MRX_OP_RETLIT   4'h5
`define MRX_OP_ROTL     4'h6
`define MRX_OP_ROTR     4'h7
`define MRX_OP_PWRDN    4'h8
`define MRX_OP_RETSUB   4'h9
// Bus responses
`define MRX_RESP_OKAY   2'b00
`define MRX_RESP_SLVERR 2'b10
// Sizes and timing
`define MRX_CLK_PER_ICYC 4
`define MRX_STACK_DEPTH  8
`define MRX_PC_W         13
`define MRX_FILE_DEPTH   128
`define MRX_FILE_AW      7
`endif

// file: design/mrx_exec.sv
// Executor for moves, returns, rotates and power-down, with AXI4-Lite access
`timescale 1ns/10ps
`include "mrx_cfg.svh"

module mrx_exec
  import mrx_pkg::*;
#(
  parameter int ADDR_W = 8,
  parameter int DIV    = `MRX_CLK_PER_ICYC,
  parameter int STK_D  = `MRX_STACK_DEPTH,
  parameter int PC_W   = `MRX_PC_W
) (
  // Clock and reset
  input  wire logic              CLK_SYS,
  input  wire logic              RST,
  // Write address channel
  input  wire logic              AWVALID,
  output logic                   AWREADY,
  input  wire logic [ADDR_W-1:0] AWADDR,
  input  wire logic [2:0]        AWPROT,
  // Write data channel
  input  wire logic              WVALID,
  output logic                   WREADY,
  input  wire logic [31:0]       WDATA,
  input  wire logic [3:0]        WSTRB,
  // Write response channel
  output logic                   BVALID,
  input  wire logic              BREADY,
  output logic      [1:0]        BRESP,
  // Read address channel
  input  wire logic              ARVALID,
  output logic                   ARREADY,
  input  wire logic [ADDR_W-1:0] ARADDR,
  input  wire logic [2:0]        ARPROT,
  // Read data channel
  output logic                   RVALID,
  input  wire logic              RREADY,
  output logic      [31:0]       RDATA,
  output logic      [1:0]        RRESP,
  // Core state
  output logic                   SLEEP_ACTIVE,
  output logic                   GLOBAL_INT_EN
);
  localparam int SPW = $clog2(STK_D);
  localparam int DW  = $clog2(DIV + 1);

  mrx_state_t        st;
  mrx_instr_t        ir;
  logic [7:0]        acc;
  logic              carry;
  logic              zero;
  logic              timeout_flag;
  logic              powerdown_flag;
  logic [PC_W-1:0]   pc;
  logic [PC_W-1:0]   stk [STK_D];
  logic [SPW-1:0]    sp;
  logic [PC_W-1:0]   stk_top;
  logic [7:0]        watchdog_count;
  logic [7:0]        wd_pre;
  logic [DW-1:0]     div_cnt;
  logic              tick;
  logic              fire;
  logic              busy;
  logic [6:0]        peek;
  logic [7:0]        ram_q;
  logic              ram_we;
  logic [6:0]        ram_wa;
  logic [7:0]        ram_wd;
  logic [7:0]        res;
  logic              next_carry;
  logic              aw_have;
  logic              w_have;
  logic [ADDR_W-1:0] aw_q;
  logic [31:0]       wd_q;
  logic              wr_go;
  logic              wr_ok;
  logic              ar_have;
  logic [ADDR_W-1:0] ar_q;
  logic [31:0]       next_rdata;
  logic              next_rok;

  //----------------------------------------------------------------
  // Register bus
  //----------------------------------------------------------------
  assign wr_go = aw_have && w_have && !BVALID;

  // Write address capture
  always_ff @(posedge CLK_SYS) begin
    if (RST) begin
      AWREADY <= 1'b0;
      aw_have <= 1'b0;
      aw_q    <= '0;
    end else if (AWREADY && AWVALID) begin
      AWREADY <= 1'b0;
      aw_have <= 1'b1;
      aw_q    <= AWADDR;
    end else if (wr_go) begin
      aw_have <= 1'b0;
    end else if (!aw_have && !BVALID) begin
      AWREADY <= 1'b1;
    end
  end

  // Write data capture, strobes turn into a bit mask
  logic [31:0] wm_q;
  always_ff @(posedge CLK_SYS) begin
    if (RST) begin
      WREADY <= 1'b0;
      w_have <= 1'b0;
      wd_q   <= '0;
      wm_q   <= '0;
    end else if (WREADY && WVALID) begin
      WREADY <= 1'b0;
      w_have <= 1'b1;
      wd_q   <= WDATA;
      wm_q   <= {{8{WSTRB[3]}}, {8{WSTRB[2]}}, {8{WSTRB[1]}}, {8{WSTRB[0]}}};
    end else if (wr_go) begin
      w_have <= 1'b0;
    end else if (!w_have && !BVALID) begin
      WREADY <= 1'b1;
    end
  end

  // Write acceptance: instructions only when idle, most others not while busy
  always_comb begin
    case (aw_q)
      ADDR_W'(`MRX_OFS_INSTR):  wr_ok = (st == ST_IDLE);
      ADDR_W'(`MRX_OFS_CTRL):   wr_ok = 1'b1;
      ADDR_W'(`MRX_OFS_ACC),
      ADDR_W'(`MRX_OFS_STATUS),
      ADDR_W'(`MRX_OFS_PC),
      ADDR_W'(`MRX_OFS_STACK),
      ADDR_W'(`MRX_OFS_FADDR),
      ADDR_W'(`MRX_OFS_FDATA):  wr_ok = !busy;
      default:                  wr_ok = 1'b0;
    endcase
  end

  // Write response
  always_ff @(posedge CLK_SYS) begin
    if (RST) begin
      BVALID <= 1'b0;
      BRESP  <= `MRX_RESP_OKAY;
    end else if (wr_go) begin
      BVALID <= 1'b1;
      BRESP  <= wr_ok ? `MRX_RESP_OKAY : `MRX_RESP_SLVERR;
    end else if (BREADY) begin
      BVALID <= 1'b0;
    end
  end

  // Read address capture
  always_ff @(posedge CLK_SYS) begin
    if (RST) begin
      ARREADY <= 1'b0;
      ar_have <= 1'b0;
      ar_q    <= '0;
    end else if (ARREADY && ARVALID) begin
      ARREADY <= 1'b0;
      ar_have <= 1'b1;
      ar_q    <= ARADDR;
    end else if (ar_have) begin
      ar_have <= 1'b0;
    end else if (!RVALID) begin
      ARREADY <= 1'b1;
    end
  end

  // Read data selection
  always_comb begin
    next_rdata = '0;
    next_rok   = 1'b1;
    case (ar_q)
      ADDR_W'(`MRX_OFS_INSTR):  next_rdata = 32'({ir.op, 7'h00, ir.dest, ir.arg});
      ADDR_W'(`MRX_OFS_ACC):    next_rdata = 32'(acc);
      ADDR_W'(`MRX_OFS_STATUS): begin
        next_rdata[`MRX_ST_CARRY] = carry;
        next_rdata[`MRX_ST_ZERO]  = zero;
        next_rdata[`MRX_ST_PDOWN] = powerdown_flag;
        next_rdata[`MRX_ST_TMOUT] = timeout_flag;
        next_rdata[`MRX_ST_INTEN] = GLOBAL_INT_EN;
        next_rdata[`MRX_ST_BUSY]  = busy;
        next_rdata[`MRX_ST_SLEEP] = SLEEP_ACTIVE;
      end
      ADDR_W'(`MRX_OFS_PC):     next_rdata = 32'(pc);
      ADDR_W'(`MRX_OFS_STACK):  begin
        next_rdata[PC_W-1:0] = stk_top;
        next_rdata[`MRX_STK_SP_LO +: SPW] = sp;
      end
      ADDR_W'(`MRX_OFS_WDOG):   next_rdata = 32'({wd_pre, watchdog_count});
      ADDR_W'(`MRX_OFS_FADDR):  next_rdata = 32'(peek);
      ADDR_W'(`MRX_OFS_FDATA):  next_rdata = 32'(ram_q);
      ADDR_W'(`MRX_OFS_CTRL):   next_rdata = '0;
      default:                  next_rok   = 1'b0;
    endcase
  end

  // Read response
  always_ff @(posedge CLK_SYS) begin
    if (RST) begin
      RVALID <= 1'b0;
      RDATA  <= '0;
      RRESP  <= `MRX_RESP_OKAY;
    end else if (ar_have) begin
      RVALID <= 1'b1;
      RDATA  <= next_rdata;
      RRESP  <= next_rok ? `MRX_RESP_OKAY : `MRX_RESP_SLVERR;
    end else if (RREADY) begin
      RVALID <= 1'b0;
    end
  end

  //----------------------------------------------------------------
  // Instruction cycle timing and sequencing
  //----------------------------------------------------------------
  // Instruction cycle enable; halts with the oscillator in sleep
  always_ff @(posedge CLK_SYS) begin
    if (RST || SLEEP_ACTIVE) begin
      div_cnt <= '0;
      tick    <= 1'b0;
    end else if (div_cnt == DW'(DIV - 1)) begin
      div_cnt <= '0;
      tick    <= 1'b1;
    end else begin
      div_cnt <= div_cnt + 1'b1;
      tick    <= 1'b0;
    end
  end

  assign busy = (st == ST_FETCH) || (st == ST_RUN) || (st == ST_WAIT2);
  assign fire = (st == ST_RUN) && tick;
  logic wr_hit;
  assign wr_hit = wr_go && wr_ok;

  // Sequencer: fetch operand, execute on a cycle edge, second cycle for returns
  always_ff @(posedge CLK_SYS) begin
    if (RST) begin
      st           <= ST_IDLE;
      ir           <= '0;
      SLEEP_ACTIVE <= 1'b0;
    end else begin
      case (st)
        ST_IDLE: begin
          if (wr_hit && aw_q == ADDR_W'(`MRX_OFS_INSTR)) begin
            ir <= '{op:   wd_q[`MRX_IW_OP_HI:`MRX_IW_OP_LO],
                    dest: wd_q[`MRX_IW_DEST],
                    arg:  wd_q[`MRX_IW_ARG_HI:0]};
            st <= ST_FETCH;
          end
        end
        ST_FETCH: st <= ST_RUN;
        ST_RUN: begin
          if (tick) begin
            case (ir.op)
              `MRX_OP_RETINT, `MRX_OP_RETLIT, `MRX_OP_RETSUB: begin
                st <= ST_WAIT2;
              end
              `MRX_OP_PWRDN: begin
                st           <= ST_SLEEP;
                SLEEP_ACTIVE <= 1'b1;
              end
              default: st <= ST_IDLE;
            endcase
          end
        end
        ST_WAIT2: if (tick) st <= ST_IDLE;
        ST_SLEEP: begin
          if (wr_hit && aw_q == ADDR_W'(`MRX_OFS_CTRL) && wd_q[`MRX_CTRL_WAKE]) begin
            st           <= ST_IDLE;
            SLEEP_ACTIVE <= 1'b0;
          end
        end
        default: st <= ST_IDLE;
      endcase
    end
  end

  //----------------------------------------------------------------
  // Datapath
  //----------------------------------------------------------------
  // Rotates through carry
  always_comb begin
    res        = ram_q;
    next_carry = carry;
    case (ir.op)
      `MRX_OP_ROTL: begin
        res        = {ram_q[6:0], carry};
        next_carry = ram_q[7];
      end
      `MRX_OP_ROTR: begin
        res        = {carry, ram_q[7:1]};
        next_carry = ram_q[0];
      end
      default: ;
    endcase
  end

  // File register write port: executor or bus
  always_comb begin
    ram_we = 1'b0;
    ram_wa = peek;
    ram_wd = wd_q[7:0];
    if (fire) begin
      ram_wa = ir.arg[6:0];
      case (ir.op)
        `MRX_OP_STORE: begin
          ram_we = 1'b1;
          ram_wd = acc;
        end
        `MRX_OP_COPY, `MRX_OP_ROTL, `MRX_OP_ROTR: begin
          ram_we = ir.dest;
          ram_wd = res;
        end
        default: ;
      endcase
    end else if (wr_hit && aw_q == ADDR_W'(`MRX_OFS_FDATA) && wm_q[0]) begin
      ram_we = 1'b1;
    end
  end

  mrx_file_ram #(
    .DEPTH (`MRX_FILE_DEPTH),
    .AW    (`MRX_FILE_AW),
    .W     (8)
  ) u_ram (
    .clk   (CLK_SYS),
    .we    (ram_we),
    .waddr (ram_wa),
    .wdata (ram_wd),
    .raddr (busy ? ir.arg[6:0] : peek),
    .rdata (ram_q)
  );

  // Accumulator
  always_ff @(posedge CLK_SYS) begin
    if (RST) begin
      acc <= '0;
    end else if (fire) begin
      case (ir.op)
        `MRX_OP_COPY, `MRX_OP_ROTL, `MRX_OP_ROTR: begin
          if (!ir.dest) acc <= res;
        end
        `MRX_OP_LOADLIT, `MRX_OP_RETLIT: acc <= ir.arg;
        default: ;
      endcase
    end else if (wr_hit && aw_q == ADDR_W'(`MRX_OFS_ACC)) begin
      acc <= (acc & ~wm_q[7:0]) | (wd_q[7:0] & wm_q[7:0]);
    end
  end

  // Status flags; loads and the literal and subroutine returns leave them alone, the interrupt return sets GLOBAL_INT_EN
  always_ff @(posedge CLK_SYS) begin
    if (RST) begin
      carry          <= `MRX_RST_FLAG;
      zero           <= `MRX_RST_FLAG;
      GLOBAL_INT_EN  <= `MRX_RST_FLAG;
      timeout_flag   <= `MRX_RST_TMOUT;
      powerdown_flag <= `MRX_RST_PDOWN;
    end else if (fire) begin
      case (ir.op)
        `MRX_OP_COPY:   zero <= (res == 8'h00);
        `MRX_OP_ROTL,
        `MRX_OP_ROTR:   carry <= next_carry;
        `MRX_OP_RETINT: GLOBAL_INT_EN <= 1'b1;
        `MRX_OP_PWRDN: begin
          timeout_flag   <= 1'b1;
          powerdown_flag <= 1'b0;
        end
        default: ;
      endcase
    end else if (wr_hit && aw_q == ADDR_W'(`MRX_OFS_STATUS) && wm_q[0]) begin
      carry         <= wd_q[`MRX_ST_CARRY];
      zero          <= wd_q[`MRX_ST_ZERO];
      GLOBAL_INT_EN <= wd_q[`MRX_ST_INTEN];
    end
  end

  // Program counter and return stack
  assign stk_top = stk[sp - 1'b1];
  always_ff @(posedge CLK_SYS) begin
    if (RST) begin
      pc <= '0;
      sp <= '0;
    end else if (fire) begin
      case (ir.op)
        `MRX_OP_RETINT, `MRX_OP_RETLIT, `MRX_OP_RETSUB: begin
          pc <= stk_top;
          sp <= sp - 1'b1;
        end
        default: pc <= pc + 1'b1;
      endcase
    end else if (wr_hit && aw_q == ADDR_W'(`MRX_OFS_PC)) begin
      pc <= wd_q[PC_W-1:0];
    end else if (wr_hit && aw_q == ADDR_W'(`MRX_OFS_STACK)) begin
      sp <= sp + 1'b1;
    end
  end

  // Stack entries, pushed by software
  for (genvar g = 0; g < STK_D; g++) begin : g_stk
    always_ff @(posedge CLK_SYS) begin
      if (RST) begin
        stk[g] <= '0;
      end else if (wr_hit && aw_q == ADDR_W'(`MRX_OFS_STACK) && sp == SPW'(g)) begin
        stk[g] <= wd_q[PC_W-1:0];
      end
    end
  end

  // Watchdog count and prescaler, cleared by power-down
  always_ff @(posedge CLK_SYS) begin
    if (RST || (fire && ir.op == `MRX_OP_PWRDN)) begin
      watchdog_count <= `MRX_WDOG_CLR;
      wd_pre         <= `MRX_WDOG_CLR;
    end else if (tick) begin
      wd_pre <= wd_pre + 1'b1;
      if (&wd_pre) watchdog_count <= watchdog_count + 1'b1;
    end
  end

  // Bus peek address for file registers
  always_ff @(posedge CLK_SYS) begin
    if (RST) begin
      peek <= '0;
    end else if (wr_hit && aw_q == ADDR_W'(`MRX_OFS_FADDR)) begin
      peek <= wd_q[6:0];
    end
  end

  //----------------------------------------------------------------
  // Checks
  //----------------------------------------------------------------
  default clocking cb @(posedge CLK_SYS); endclocking
  default disable iff (RST);

  chk_copy_dest: assert property (fire && ir.op == `MRX_OP_COPY && !ir.dest |=>
    acc == $past(ram_q)) else $error("copy did not reach accumulator");
  chk_copy_zero: assert property (fire && ir.op == `MRX_OP_COPY |=>
    zero == ($past(ram_q) == 8'h00)) else $error("copy zero flag wrong");
  chk_lit_load: assert property (fire && ir.op == `MRX_OP_LOADLIT |=>
    acc == $past(ir.arg) && $stable(carry) && $stable(zero)) else $error("literal load wrong");
  chk_int_return: assert property (fire && ir.op == `MRX_OP_RETINT |=>
    GLOBAL_INT_EN && pc == $past(stk_top)) else $error("interrupt return wrong");
  chk_store_write: assert property (fire && ir.op == `MRX_OP_STORE |->
    ram_we && ram_wd == acc) else $error("store did not write");
  chk_litret_two: assert property (fire && ir.op == `MRX_OP_RETLIT |=>
    acc == $past(ir.arg) && st == ST_WAIT2) else $error("literal return wrong");
  chk_rot_left: assert property (fire && ir.op == `MRX_OP_ROTL |=>
    carry == $past(ram_q[7])) else $error("left rotate carry wrong");
  chk_rot_right: assert property (fire && ir.op == `MRX_OP_ROTR && !ir.dest |=>
    acc == {$past(carry), $past(ram_q[7:1])}) else $error("right rotate wrong");
  chk_sleep_wdog: assert property (fire && ir.op == `MRX_OP_PWRDN |=>
    watchdog_count == 8'h00 && wd_pre == 8'h00) else $error("watchdog not cleared");
  chk_sleep_flags: assert property (fire && ir.op == `MRX_OP_PWRDN |=>
    timeout_flag && !powerdown_flag && $stable(carry)) else $error("sleep flags wrong");
  chk_sleep_stop: assert property (fire && ir.op == `MRX_OP_PWRDN |=>
    SLEEP_ACTIVE ##1 !tick [*3]) else $error("sleep did not stop cycles");
  chk_ret_pop: assert property (fire && ir.op == `MRX_OP_RETSUB |=>
    pc == $past(stk_top) && sp == $past(sp) - 1'b1) else $error("return pop wrong");
  chk_nop_pc: assert property (fire && ir.op == `MRX_OP_NOP |=>
    pc == $past(pc) + 1'b1 && $stable(acc)) else $error("nop changed state");
  chk_one_cycle: assert property (fire && ir.op == `MRX_OP_STORE |=>
    st == ST_IDLE && pc == $past(pc) + 1'b1) else $error("single cycle wrong");

  cov_copy_back: cover property (fire && ir.op == `MRX_OP_COPY && ir.dest);
  cov_ret_sub: cover property (fire && ir.op == `MRX_OP_RETSUB);
  cov_wake: cover property (st == ST_SLEEP ##1 st == ST_IDLE);
endmodule

// file: design/mrx_file_ram.sv
// File register memory with registered read data
`timescale 1ns/10ps
module mrx_file_ram
  import mrx_pkg::*;
#(
  parameter int DEPTH = 128,
  parameter int AW    = 7,
  parameter int W     = 8
) (
  // Clock
  input  wire logic          clk,
  // Write port
  input  wire logic          we,
  input  wire logic [AW-1:0] waddr,
  input  wire logic [W-1:0]  wdata,
  // Read port
  input  wire logic [AW-1:0] raddr,
  output logic      [W-1:0]  rdata
);
  logic [W-1:0] mem [DEPTH];

  // Write
  always_ff @(posedge clk) begin
    if (we) begin
      mem[waddr] <= wdata;
    end
  end

  // Registered read
  always_ff @(posedge clk) begin
    rdata <= mem[raddr];
  end
endmodule

// file: design/mrx_pkg.sv
// Types shared by the executor files
package mrx_pkg;
  // Executor states, one-hot
  typedef enum logic [4:0] {
    ST_IDLE  = 5'b00001,
    ST_FETCH = 5'b00010,
    ST_RUN   = 5'b00100,
    ST_WAIT2 = 5'b01000,
    ST_SLEEP = 5'b10000
  } mrx_state_t;
  // Decoded instruction word
  typedef struct packed {
    logic [3:0] op;
    logic       dest;
    logic [7:0] arg;
  } mrx_instr_t;
endpackage

// file: tb/mrx_exec_tb.sv
// Self-checking bench for the move, return, rotate and power-down executor
`timescale 1ns/10ps
`include "mrx_cfg.svh"
module mrx_exec_tb
  import mrx_pkg::*;
;
  // ----------------------------------------
  // Signals, model state and design
  // ----------------------------------------
  logic        CLK_SYS = 1'b0;
  logic        RST     = 1'b1;
  logic        AWVALID = 1'b0;
  logic        WVALID  = 1'b0;
  logic        BREADY  = 1'b0;
  logic        ARVALID = 1'b0;
  logic        RREADY  = 1'b0;
  logic [7:0]  AWADDR  = 8'h00;
  logic [7:0]  ARADDR  = 8'h00;
  logic [31:0] WDATA   = 32'h0;
  logic [31:0] RDATA;
  logic [1:0]  BRESP, RRESP;
  logic        AWREADY, WREADY, BVALID, ARREADY, RVALID, SLEEP_ACTIVE, GLOBAL_INT_EN;
  logic [31:0] rv;
  logic [1:0]  rr;
  int          miscompares = 0;
  int          n_checks    = 0;
  int          acc, cy, zf, tmo_f, pdn_f, ien, slp, pc;
  int          fm[128];
  int          stk[$];

  mrx_exec #(.DIV(2)) mrx_exec_i (
    .CLK_SYS(CLK_SYS), .RST(RST), .AWVALID(AWVALID), .AWREADY(AWREADY), .AWADDR(AWADDR),
    .AWPROT(3'h0), .WVALID(WVALID), .WREADY(WREADY), .WDATA(WDATA), .WSTRB(4'hf),
    .BVALID(BVALID), .BREADY(BREADY), .BRESP(BRESP), .ARVALID(ARVALID), .ARREADY(ARREADY),
    .ARADDR(ARADDR), .ARPROT(3'h0), .RVALID(RVALID), .RREADY(RREADY), .RDATA(RDATA),
    .RRESP(RRESP), .SLEEP_ACTIVE(SLEEP_ACTIVE), .GLOBAL_INT_EN(GLOBAL_INT_EN));

  // Clock, 40 ns period
  always #20 CLK_SYS = ~CLK_SYS;

  // ----------------------------------------
  // Bus and compare tasks
  // ----------------------------------------
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      miscompares++;
      $display("[ERR] %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic end_sim();
    $display("checks %0d mismatches %0d", n_checks, miscompares);
    if (miscompares == 0 && n_checks > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask

  // Write: address and data offered together, response awaited
  task automatic axw(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
    bit aw, w, b;
    aw = 0;
    w = 0;
    b = 0;
    r = 2'b11;
    AWADDR <= a;
    WDATA <= d;
    AWVALID <= 1'b1;
    WVALID <= 1'b1;
    BREADY <= 1'b1;
    while (!b) begin
      @(posedge CLK_SYS);
      if (aw && w && BVALID) begin
        b = 1;
        r = BRESP;
        BREADY <= 1'b0;
      end
      if (!aw && AWREADY) begin
        aw = 1;
        AWVALID <= 1'b0;
      end
      if (!w && WREADY) begin
        w = 1;
        WVALID <= 1'b0;
      end
    end
    @(posedge CLK_SYS);
  endtask

  // Read: address held until taken, data taken with the response
  task automatic axr(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    bit ar, b;
    ar = 0;
    b = 0;
    r = 2'b11;
    d = 32'h0;
    ARADDR <= a;
    ARVALID <= 1'b1;
    RREADY <= 1'b1;
    while (!b) begin
      @(posedge CLK_SYS);
      if (ar && RVALID) begin
        b = 1;
        d = RDATA;
        r = RRESP;
        RREADY <= 1'b0;
      end
      if (!ar && ARREADY) begin
        ar = 1;
        ARVALID <= 1'b0;
      end
    end
    @(posedge CLK_SYS);
  endtask

  // Issue one instruction and wait for the core to leave busy
  task automatic exec(input int op, input int d, input int arg);
    int n;
    axw(`MRX_OFS_INSTR, 32'(op << 16 | d << 8 | arg), rr);
    chk("instr resp", 32'(rr), 32'h0);
    n = 0;
    rv = 32'h100;
    while (rv[8] && n < 50) begin
      axr(`MRX_OFS_STATUS, rv, rr);
      n++;
    end
    chk("busy", 32'(rv[8]), 32'h0);
  endtask

  // Accumulator, status and program counter against the model
  task automatic cmp_state();
    int se;
    se = cy | zf << 2 | pdn_f << 3 | tmo_f << 4 | ien << 7 | slp << 9;
    axr(`MRX_OFS_ACC, rv, rr);
    chk("acc", rv, 32'(acc));
    axr(`MRX_OFS_STATUS, rv, rr);
    chk("status", rv, 32'(se));
    axr(`MRX_OFS_PC, rv, rr);
    chk("pc", rv, 32'(pc));
  endtask

  // Hang guard, well beyond the expected run
  initial begin
    #400000;
    miscompares++;
    end_sim();
  end

  // ----------------------------------------
  // Test sequence
  // ----------------------------------------
  initial begin
    int a, v, op, d, res, lit;
    int ops[6];
    ops = '{0, 1, 2, 3, 6, 7};
    void'($urandom(25));
    acc = 0;
    cy = 0;
    zf = 0;
    tmo_f = 1;
    pdn_f = 1;
    ien = 0;
    slp = 0;
    pc = 0;
    repeat (8) @(posedge CLK_SYS);
    RST <= 1'b0;
    @(posedge CLK_SYS);
    cmp_state();
    $display("test reset done");
    // Moves, nop and rotates on random registers, values and destinations
    for (int i = 0; i < 36; i++) begin
      a = $urandom_range(127);
      v = (i < 6) ? 0 : $urandom_range(255);
      op = ops[i % 6];
      d = $urandom_range(1);
      axw(`MRX_OFS_FADDR, 32'(a), rr);
      axw(`MRX_OFS_FDATA, 32'(v), rr);
      fm[a] = v;
      cy = $urandom_range(1);
      axw(`MRX_OFS_STATUS, 32'(cy | zf << 2 | ien << 7), rr);
      res = v;
      case (op)
        1: zf = (v == 0);
        2: acc = v;
        3: fm[a] = acc;
        6: begin
          res = (v << 1 | cy) & 8'hff;
          cy = v >> 7;
        end
        7: begin
          res = v >> 1 | cy << 7;
          cy = v & 1;
        end
        default: ;
      endcase
      if (op == 1 || op == 6 || op == 7) begin
        if (d == 1) fm[a] = res;
        else acc = res;
      end
      exec(op, d, (op == 2) ? v : a);
      pc = (pc + 1) & 13'h1fff;
      cmp_state();
      axr(`MRX_OFS_FDATA, rv, rr);
      chk("file reg", rv, 32'(fm[a]));
    end
    $display("test moves and rotates done");
    // Three returns unwinding pushed addresses
    for (int k = 0; k < 3; k++) begin
      v = $urandom_range(13'h1fff);
      axw(`MRX_OFS_STACK, 32'(v), rr);
      stk.push_back(v);
    end
    foreach (ops[k]) begin
      if (k < 3) begin
        op = (k == 0) ? 9 : (k == 1) ? 5 : 4;
        lit = $urandom_range(255);
        exec(op, 0, lit);
        pc = stk.pop_back();
        if (op == 5) acc = lit;
        if (op == 4) ien = 1;
        cmp_state();
        chk("int enable pin", 32'(GLOBAL_INT_EN), 32'(ien));
      end
    end
    $display("test returns done");
    // Power-down, refusal while asleep, frozen watchdog, wake
    exec(8, 0, 0);
    tmo_f = 1;
    pdn_f = 0;
    slp = 1;
    pc = (pc + 1) & 13'h1fff;
    cmp_state();
    axr(`MRX_OFS_WDOG, rv, rr);
    chk("wdog", rv, 32'h0);
    chk("sleep pin", 32'(SLEEP_ACTIVE), 32'h1);
    axw(`MRX_OFS_INSTR, 32'h0, rr);
    chk("instr asleep", 32'(rr), 32'(`MRX_RESP_SLVERR));
    repeat (40) @(posedge CLK_SYS);
    axr(`MRX_OFS_WDOG, rv, rr);
    chk("wdog asleep", rv, 32'h0);
    axw(`MRX_OFS_CTRL, 32'h1, rr);
    slp = 0;
    cmp_state();
    chk("sleep pin", 32'(SLEEP_ACTIVE), 32'h0);
    $display("test power-down done");
    // Unmapped addresses
    axr(8'h24, rv, rr);
    chk("unmapped rresp", 32'(rr), 32'(`MRX_RESP_SLVERR));
    chk("unmapped rdata", rv, 32'h0);
    axw(8'h30, 32'h5a, rr);
    chk("unmapped bresp", 32'(rr), 32'(`MRX_RESP_SLVERR));
    $display("test unmapped done");
    end_sim();
  end
endmodule
